// ### hw/usfr_defs.vh
// Register map, field positions and reset values of the serial port block.
// Assumes a plain address/strobe register port with byte addresses.
`ifndef USFR_DEFS_VH
`define USFR_DEFS_VH
`define USFR_OFS_CTRL1      8'h04
`define USFR_OFS_STAT       8'h08
`define USFR_OFS_INT_EN     8'h0c
`define USFR_OFS_INT_FL     8'h10
`define USFR_OFS_RATE_INT   8'h14
`define USFR_OFS_RATE_FRAC  8'h18
`define USFR_OFS_DATA       8'h1c
`define USFR_OFS_DMA        8'h20
`define USFR_OFS_PEEK       8'h24
`define USFR_FL_LAST_BRK    9
`define USFR_FL_RECEIVE_TIMEOUT_FLAG       8
`define USFR_FL_BRK         7
`define USFR_FL_TX_LVL      6
`define USFR_FL_TX_AE       5
`define USFR_FL_RX_LVL      4
`define USFR_FL_OVR         3
`define USFR_FL_CTS         2
`define USFR_FL_PAR         1
`define USFR_FL_FRM         0
`define USFR_FIFO_DEPTH     6'd32
`define USFR_PRE_128        7'h7f
`define USFR_PRE_64         7'h3f
`define USFR_PRE_32         7'h1f
`define USFR_PRE_16         7'h0f
`define USFR_PRE_8          7'h07
`define USFR_RST_ZERO       32'h0000_0000
`endif

// ### hw/usfr_top.v
// Register side of a serial port: flags, rate divisor, FIFOs, DMA requests.
// Assumes receiver events arrive as one-cycle pulses on CLK, CTS is a pin.
//
// Contract
// - First non-break frame after a series of break frames sets bit 9; write one clears.
// - Receive timeout sets bit 8; write one clears.
// - First break frame of a series sets bit 7; write one clears.
// - Bit 6 set while transmit count at or below threshold.
// - Bit 5 set when exactly one byte stays in transmit FIFO.
// - Bit 4 set while receive count at or above threshold.
// - Character into full receive FIFO sets overrun bit 3.
// - CTS level change sets bit 2; write one clears.
// - Receive parity error sets bit 1; write one clears.
// - Receive framing error sets bit 0; write one clears.
// - Twelve-bit integer divisor sets the bit period.
// - Twelve-bit fraction applied with integer part for rate.
// - Data port read pops receive FIFO; write pushes transmit FIFO.
// - Receive DMA requests above trigger level until FIFO empty.
// - Transmit DMA requests below trigger level until FIFO full.
// - DMA config bit 1 gates receive, bit 0 gates transmit.
// - Peek returns next transmit byte unremoved, 0x00 when empty.
// - Receive threshold is a six-bit field, 0 to 32.
// - Transmit threshold is a six-bit field, 0 to 32.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "usfr_defs.vh"

module usfr_top (
  CLK,
  ARST_N,
  ADDR,
  WDATA,
  WR,
  RD,
  RDATA,
  RX_VALID,
  RX_DATA,
  RX_TIMEOUT,
  RX_BREAK,
  RX_PAR_ERR,
  RX_FRM_ERR,
  CTS_PIN,
  TX_POP,
  TX_VALID,
  TX_DATA,
  BIT_TICK,
  RX_DMA_REQ,
  TX_DMA_REQ,
  IRQ
);
  input             CLK;
  input             ARST_N;
  input      [7:0]  ADDR;
  input      [31:0] WDATA;
  input             WR;
  input             RD;
  output reg [31:0] RDATA;
  input             RX_VALID;
  input      [7:0]  RX_DATA;
  input             RX_TIMEOUT;
  input             RX_BREAK;
  input             RX_PAR_ERR;
  input             RX_FRM_ERR;
  input             CTS_PIN;
  input             TX_POP;
  output            TX_VALID;
  output     [7:0]  TX_DATA;
  output reg        BIT_TICK;
  output            RX_DMA_REQ;
  output            TX_DMA_REQ;
  output            IRQ;

  // ***************************************************************
  // Registers and FIFO storage
  // ***************************************************************
  reg [5:0]  rx_thr_q, tx_thr_q;
  reg [9:0]  int_en_q, flags_q;
  reg [2:0]  clkdiv_q;
  reg [11:0] ibaud_q, dbaud_q;
  reg [5:0]  rxdma_lvl_q, txdma_lvl_q;
  reg        rxdma_en_q, txdma_en_q;
  reg [7:0]  rx_mem [0:31];
  reg [7:0]  tx_mem [0:31];
  reg [4:0]  rx_rp_q, rx_wp_q, tx_rp_q, tx_wp_q;
  reg [5:0]  rx_cnt_q, tx_cnt_q;
  reg        brk_prev_q, cts_s1_q, cts_s2_q, cts_s3_q;
  reg [2:0]  cts_fill_q;

  wire rx_empty = (rx_cnt_q == 6'd0);
  wire rx_full  = (rx_cnt_q == `USFR_FIFO_DEPTH);
  wire tx_empty = (tx_cnt_q == 6'd0);
  wire tx_full  = (tx_cnt_q == `USFR_FIFO_DEPTH);

  wire wr_fl   = WR && (ADDR == `USFR_OFS_INT_FL);
  wire wr_data = WR && (ADDR == `USFR_OFS_DATA);
  wire rx_pop  = RD && (ADDR == `USFR_OFS_DATA) && !rx_empty;
  // Writes into a full transmit FIFO are dropped; software checks status.
  wire tx_push = wr_data && !tx_full;
  wire rx_push = RX_VALID && !rx_full;
  wire tx_pop  = TX_POP && !tx_empty;

  assign TX_VALID = !tx_empty;
  assign TX_DATA  = tx_empty ? 8'h00 : tx_mem[tx_rp_q];

  // ***************************************************************
  // FIFOs
  // ***************************************************************
  always @(posedge CLK) begin
    if (rx_push)
      rx_mem[rx_wp_q] <= RX_DATA;
    if (tx_push)
      tx_mem[tx_wp_q] <= WDATA[7:0];
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_rp_q  <= 5'h00;
      rx_wp_q  <= 5'h00;
      tx_rp_q  <= 5'h00;
      tx_wp_q  <= 5'h00;
      rx_cnt_q <= 6'h00;
      tx_cnt_q <= 6'h00;
    end else begin
      if (rx_push)
        rx_wp_q <= rx_wp_q + 5'h01;
      if (rx_pop)
        rx_rp_q <= rx_rp_q + 5'h01;
      if (rx_push && !rx_pop)
        rx_cnt_q <= rx_cnt_q + 6'h01;
      else if (rx_pop && !rx_push)
        rx_cnt_q <= rx_cnt_q - 6'h01;
      if (tx_push)
        tx_wp_q <= tx_wp_q + 5'h01;
      if (tx_pop)
        tx_rp_q <= tx_rp_q + 5'h01;
      if (tx_push && !tx_pop)
        tx_cnt_q <= tx_cnt_q + 6'h01;
      else if (tx_pop && !tx_push)
        tx_cnt_q <= tx_cnt_q - 6'h01;
    end
  end

  // ***************************************************************
  // Interrupt flags
  // ***************************************************************
  // The first synchroniser stage feeds only the second.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cts_s1_q   <= 1'b0;
      cts_s2_q   <= 1'b0;
      cts_s3_q   <= 1'b0;
      cts_fill_q <= 3'h0;
      brk_prev_q <= 1'b0;
    end else begin
      // Stage three holds a real pin sample only after three edges.
      cts_fill_q <= {cts_fill_q[1:0], 1'b1};
      cts_s1_q <= CTS_PIN;
      cts_s2_q <= cts_s1_q;
      cts_s3_q <= cts_s2_q;
      if (RX_VALID)
        brk_prev_q <= RX_BREAK;
    end
  end

  reg [9:0] set_d;
  always @* begin
    set_d = 10'h000;
    set_d[`USFR_FL_BRK]      = RX_VALID && RX_BREAK && !brk_prev_q;
    set_d[`USFR_FL_LAST_BRK] = RX_VALID && !RX_BREAK && brk_prev_q;
    set_d[`USFR_FL_RECEIVE_TIMEOUT_FLAG]    = RX_TIMEOUT;
    set_d[`USFR_FL_TX_LVL]   = (tx_cnt_q <= tx_thr_q);
    set_d[`USFR_FL_TX_AE]    = (tx_cnt_q == 6'd1);
    set_d[`USFR_FL_RX_LVL]   = (rx_cnt_q >= rx_thr_q);
    set_d[`USFR_FL_OVR]      = RX_VALID && rx_full;
    // A pin idling high would look like a change until the stages fill.
    // CTS change
    set_d[`USFR_FL_CTS]      = (cts_s2_q ^ cts_s3_q) && cts_fill_q[2];
    set_d[`USFR_FL_PAR]      = RX_VALID && RX_PAR_ERR;
    set_d[`USFR_FL_FRM]      = RX_VALID && RX_FRM_ERR;
  end

  // A set in the same cycle as a write-one-to-clear wins.
  wire [9:0] clr = wr_fl ? WDATA[9:0] : 10'h000;

  assign IRQ = |(flags_q & int_en_q);

  // ***************************************************************
  // Register writes
  // ***************************************************************
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_q     <= 10'h000;
      int_en_q    <= 10'h000;
      rx_thr_q    <= 6'h00;
      tx_thr_q    <= 6'h00;
      clkdiv_q    <= 3'h0;
      ibaud_q     <= 12'h000;
      dbaud_q     <= 12'h000;
      rxdma_lvl_q <= 6'h00;
      txdma_lvl_q <= 6'h00;
      rxdma_en_q  <= 1'b0;
      txdma_en_q  <= 1'b0;
    end else begin
      flags_q <= (flags_q & ~clr) | set_d;
      if (WR) begin
        case (ADDR)
          `USFR_OFS_CTRL1: begin
            tx_thr_q <= WDATA[13:8];
            rx_thr_q <= WDATA[5:0];
          end
          `USFR_OFS_INT_EN:
            int_en_q <= WDATA[9:0];
          `USFR_OFS_RATE_INT: begin
            clkdiv_q <= WDATA[18:16];
            ibaud_q  <= WDATA[11:0];
          end
          `USFR_OFS_RATE_FRAC:
            dbaud_q <= WDATA[11:0];
          `USFR_OFS_DMA: begin
            rxdma_lvl_q <= WDATA[21:16];
            txdma_lvl_q <= WDATA[13:8];
            rxdma_en_q  <= WDATA[1];
            txdma_en_q  <= WDATA[0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // DMA requests
  // ***************************************************************
  reg rx_dma_run_q, tx_dma_run_q;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_dma_run_q <= 1'b0;
      tx_dma_run_q <= 1'b0;
    end else begin
      if (rx_cnt_q > rxdma_lvl_q)
        rx_dma_run_q <= 1'b1;
      else if (rx_empty)
        rx_dma_run_q <= 1'b0;
      if (tx_cnt_q < txdma_lvl_q)
        tx_dma_run_q <= 1'b1;
      else if (tx_full)
        tx_dma_run_q <= 1'b0;
    end
  end
  // enable gating; levels trusted to software
  assign RX_DMA_REQ = rxdma_en_q && rx_dma_run_q && !rx_empty;
  assign TX_DMA_REQ = txdma_en_q && tx_dma_run_q && !tx_full;

  // ***************************************************************
  // Bit-rate generator
  // ***************************************************************
  // Prescaler, then divide by ibaud; dbaud/4096 accumulates an extra prescaled step.
  reg [6:0]  pre_q;
  reg [11:0] div_q;
  reg [12:0] frac_q;
  reg [6:0]  pre_max;
  always @* begin
    case (clkdiv_q)
      3'h0:    pre_max = `USFR_PRE_128;
      3'h1:    pre_max = `USFR_PRE_64;
      3'h2:    pre_max = `USFR_PRE_32;
      3'h3:    pre_max = `USFR_PRE_16;
      3'h4:    pre_max = `USFR_PRE_8;
      default: pre_max = `USFR_PRE_128;
    endcase
  end
  wire pre_tick = (pre_q >= pre_max);
  wire [12:0] frac_sum = {1'b0, frac_q[11:0]} + {1'b0, dbaud_q};
  // A fraction carry lengthens the next period by one prescaled step.
  wire [12:0] bit_last = {1'b0, ibaud_q} + {12'h000, frac_q[12]} - 13'h0001;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_q    <= 7'h00;
      div_q    <= 12'h000;
      frac_q   <= 13'h0000;
      BIT_TICK <= 1'b0;
    end else begin
      BIT_TICK <= 1'b0;
      pre_q    <= pre_tick ? 7'h00 : pre_q + 7'h01;
      if (pre_tick) begin
        if ({1'b0, div_q} >= bit_last) begin
          div_q    <= 12'h000;
          frac_q   <= frac_sum;
          BIT_TICK <= (ibaud_q != 12'h000);
        end else
          div_q <= div_q + 12'h001;
      end
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      RDATA <= `USFR_RST_ZERO;
    else if (RD) begin
      case (ADDR)
        `USFR_OFS_CTRL1:
          RDATA <= {18'h0, tx_thr_q, 2'h0, rx_thr_q};
        `USFR_OFS_STAT:
          RDATA <= {10'h0, tx_cnt_q, 2'h0, rx_cnt_q, tx_full, tx_empty,
                    rx_full, rx_empty, 4'h0};
        `USFR_OFS_INT_EN:    RDATA <= {22'h0, int_en_q};
        `USFR_OFS_INT_FL:    RDATA <= {22'h0, flags_q};
        `USFR_OFS_RATE_INT:  RDATA <= {13'h0, clkdiv_q, 4'h0, ibaud_q};
        `USFR_OFS_RATE_FRAC: RDATA <= {20'h0, dbaud_q};
        `USFR_OFS_DATA:
          RDATA <= {24'h0, rx_empty ? 8'h00 : rx_mem[rx_rp_q]};
        `USFR_OFS_DMA:
          RDATA <= {10'h0, rxdma_lvl_q, 2'h0, txdma_lvl_q, 6'h0,
                    rxdma_en_q, txdma_en_q};
        `USFR_OFS_PEEK:      RDATA <= {24'h0, TX_DATA};
        default:             RDATA <= `USFR_RST_ZERO;
      endcase
    end else
      RDATA <= `USFR_RST_ZERO;
  end

endmodule // usfr_top

// ### sim/testbench.sv
// Self-checking bench for the serial port register side.
// Assumes usfr_top, the far-side model and the bound checker.
`timescale 1ns/100ps
// ***
// Bench
// ***
module testbench;
  logic        CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        rd_q = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] seed = 32'h6277cefe;
  logic [31:0] RDATA;
  logic [7:0]  RX_DATA, TX_DATA, a, b;
  logic        RX_VALID, RX_TIMEOUT, RX_BREAK, RX_PAR_ERR, RX_FRM_ERR;
  logic        CTS_PIN, TX_POP, TX_VALID, BIT_TICK, RX_DMA_REQ, TX_DMA_REQ, IRQ;
  logic [31:0] expq[$];
  logic [7:0]  sent[$];
  logic [7:0]  txq[$];
  int          failures = 0;
  int          compares = 0;
  int          i;
  usfr_top u_usfr_top (.*);
  usfr_far_model u_usfr_far_model (.*);
  always #5 CLK = ~CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic w, r, input logic [7:0] ad, input logic [31:0] d);
    @(posedge CLK);
    WR <= w;
    RD <= r;
    ADDR <= ad;
    WDATA <= d;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    op(1'b1, 1'b0, ad, d);
    op(1'b0, 1'b0, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expq.push_back(e);
    op(1'b0, 1'b1, ad, 32'h0);
    op(1'b0, 1'b0, ad, 32'h0);
  endtask
  task automatic rx(input logic [2:0] q);
    seed = lfsr(seed);
    u_usfr_far_model.gap = seed[9:8];
    u_usfr_far_model.send(seed[7:0], q);
    sent.push_back(seed[7:0]);
  endtask
  // Levels are looked at a full cycle on, once registered requests settle.
  task automatic lvl(input string what, input logic e);
    logic s;
    @(posedge CLK);
    @(negedge CLK);
    s = what == "irq" ? IRQ : what == "tx_dma" ? TX_DMA_REQ : RX_DMA_REQ;
    check(what, {31'h0, s}, {31'h0, e});
  endtask
  task automatic tick(input int p, input int k);
    int n;
    n = 0;
    repeat (2) begin
      @(negedge CLK);
      while (BIT_TICK !== 1'b1) @(negedge CLK);
    end
    repeat (k) do begin
      @(negedge CLK);
      n++;
    end while (BIT_TICK !== 1'b1);
    check("tick", n, p);
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Read answers arrive one cycle after the strobe and are matched in order.
  always @(posedge CLK) begin
    rd_q <= RD;
    if (rd_q) check("rdata", RDATA, expq.pop_front());
  end
  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(8'h10, 32'h50);
    for (i = 0; i < 6; i++) rd(8'h14 + 8'(4 * i), 32'h0);
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = i[0] ? 8'h18 : 8'h14;
      expq.push_back(seed & (i[0] ? 32'h0fff : 32'h0007_0fff));
      op(1'b1, 1'b0, a, seed);
      op(1'b0, 1'b1, a, 32'h0);
    end
    wr(8'h18, 32'h0);
    for (i = 0; i < 6; i++) begin
      wr(8'h14, (i << 16) | 32'h3);
      tick(i == 5 ? 384 : 384 >> i, 1);
    end
    wr(8'h18, 32'h800);
    wr(8'h14, 32'h0004_0003);
    tick(56, 2);
    $display("test registers done");
    wr(8'h04, 32'h3);
    wr(8'h20, 32'h0004_0002);
    for (i = 0; i < 33; i++) begin
      rx(3'b000);
      if (i == 3 || i == 4) lvl("rx_dma", i == 4);
    end
    b = sent.pop_back();
    rd(8'h10, 32'h58);
    rd(8'h08, 32'h0000_2060);
    rd(8'h04, 32'h3);
    for (i = 0; i < 32; i++) begin
      rd(8'h1c, {24'h0, sent.pop_front()});
      if (i >= 30) lvl("rx_dma", i == 30);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h40);
    wr(8'h04, 32'h20);
    rx(3'b010);
    rx(3'b001);
    rx(3'b100);
    rx(3'b000);
    u_usfr_far_model.timeout();
    u_usfr_far_model.toggle_cts();
    repeat (4) @(posedge CLK);
    rd(8'h10, 32'h3c7);
    wr(8'h10, 32'h281);
    rd(8'h10, 32'h146);
    $display("test receive done");
    wr(8'h20, 32'h0000_0801);
    lvl("tx_dma", 1'b1);
    for (i = 0; i < 33; i++) begin
      seed = lfsr(seed);
      if (i < 32) txq.push_back(seed[7:0]);
      wr(8'h1c, seed);
      if (i >= 30) lvl("tx_dma", i == 30);
    end
    rd(8'h24, {24'h0, txq[0]});
    rd(8'h24, {24'h0, txq[0]});
    wr(8'h10, 32'hffff_ffff);
    for (i = 0; i < 32; i++) begin
      u_usfr_far_model.pop(b);
      check("tx_data", b, txq.pop_front());
      if (i == 30) rd(8'h10, 32'h20);
    end
    rd(8'h24, 32'h0);
    wr(8'h0c, 32'h40);
    lvl("irq", 1'b1);
    wr(8'h0c, 32'h0);
    lvl("irq", 1'b0);
    $display("test transmit done");
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge CLK);
    failures++;
    report_and_stop();
  end
endmodule // testbench

// ### sim/usfr_checker.sv
// Port checker for the serial port register side.
// Assumes a bind into usfr_top and CLK as the only clock.
`timescale 1ns/100ps
// ***
// Checker
// ***
module usfr_checker (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        RX_VALID,
  input wire logic        TX_VALID,
  input wire logic [7:0]  TX_DATA,
  input wire logic        BIT_TICK,
  input wire logic        RX_DMA_REQ,
  input wire logic        TX_DMA_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire cfg_wr  = WR && ADDR == 8'h20;
  wire rx_pop  = RD && ADDR == 8'h1c;
  wire tx_push = WR && ADDR == 8'h1c;
  sequence rd_at(logic [7:0] a); RD && ADDR == a; endsequence
  sequence wr_at(logic [7:0] a); WR && ADDR == a; endsequence
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero");
  AST_PEEK_EMPTY: assert property (!TX_VALID |-> TX_DATA == 8'h00)
    else $error("empty head not zero");
  AST_PEEK_READ: assert property (rd_at(8'h24) |=>
    RDATA == {24'h0, $past(TX_DATA)}) else $error("peek data wrong");
  AST_INT_BACK: assert property (wr_at(8'h14) ##1 rd_at(8'h14) |=>
    ((RDATA ^ $past(WDATA, 2)) & 32'h0007_0fff) == 32'h0)
    else $error("divisor read back wrong");
  AST_TICK_GAP: assert property (BIT_TICK |=> !BIT_TICK [*7])
    else $error("bit ticks too close");
  // The run latch sets one cycle after the push or level write allowing it.
  AST_RXDMA_RISE: assert property ($rose(RX_DMA_REQ) |->
    $past(RX_VALID, 2) || $past(RX_VALID) || $past(cfg_wr, 2) ||
    $past(cfg_wr)) else $error("rx request rose");
  AST_RXDMA_FALL: assert property ($fell(RX_DMA_REQ) |->
    $past(rx_pop) || $past(cfg_wr)) else $error("rx request fell");
  AST_TXDMA_FALL: assert property ($fell(TX_DMA_REQ) |->
    $past(tx_push) || $past(cfg_wr)) else $error("tx request fell");
endmodule // usfr_checker

bind usfr_top usfr_checker u_usfr_checker (.*);

// ### sim/usfr_far_model.sv
// Far side: remote transmitter events, modem pin and transmit pops.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps
// ***
// Far side
// ***
module usfr_far_model (
  input  wire logic       CLK,
  output logic            RX_VALID = 1'b0,
  output logic [7:0]      RX_DATA = 8'h00,
  output logic            RX_TIMEOUT = 1'b0,
  output logic            RX_BREAK = 1'b0,
  output logic            RX_PAR_ERR = 1'b0,
  output logic            RX_FRM_ERR = 1'b0,
  output logic            CTS_PIN = 1'b0,
  output logic            TX_POP = 1'b0,
  input  wire logic [7:0] TX_DATA
);
  int gap = 0;
  // Data is inverted after each pulse so a stale byte never looks fresh.
  task automatic send(input logic [7:0] d, input logic [2:0] q);
    repeat (gap) @(posedge CLK);
    @(posedge CLK);
    RX_VALID <= 1'b1;
    RX_DATA <= d;
    {RX_BREAK, RX_PAR_ERR, RX_FRM_ERR} <= q;
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX_DATA <= ~d;
    {RX_BREAK, RX_PAR_ERR, RX_FRM_ERR} <= 3'b000;
  endtask
  task automatic timeout;
    @(posedge CLK);
    RX_TIMEOUT <= 1'b1;
    @(posedge CLK);
    RX_TIMEOUT <= 1'b0;
  endtask
  task automatic toggle_cts;
    @(posedge CLK);
    CTS_PIN <= ~CTS_PIN;
  endtask
  task automatic pop(output logic [7:0] d);
    @(posedge CLK);
    TX_POP <= 1'b1;
    @(posedge CLK);
    d = TX_DATA;
    TX_POP <= 1'b0;
  endtask
endmodule // usfr_far_model
